/* src/ssr_pkg.sv */
// Constants, state types and shared decode for the supply supervisor.
// Assumes a single 200 MHz clock feeding every user of this package.
package ssr_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_KHZ = 200_000;
   localparam int RST_TIMEOUT_MS = 200;
   localparam int WDT_TIMEOUT_MS = 1600;
   localparam int GRACE_US = 18;
   localparam int CNT_W = 29;
   localparam int GRACE_W = 12;
   localparam logic [CNT_W-1:0] RST_CYCLES = CNT_W'(RST_TIMEOUT_MS * CLK_KHZ);
   localparam logic [CNT_W-1:0] WDT_CYCLES = CNT_W'(WDT_TIMEOUT_MS * CLK_KHZ);
   localparam logic [GRACE_W-1:0] GRACE_CYCLES = GRACE_W'((GRACE_US * CLK_KHZ) / 1000);
   localparam logic [CNT_W-1:0] CNT_ZERO = 29'h0000_0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 29'h0000_0001;
   localparam logic [GRACE_W-1:0] GRACE_ZERO = 12'h000;
   localparam logic [GRACE_W-1:0] GRACE_ONE = 12'h001;

   // ****************************************
   // Synchroniser lanes
   // ****************************************
   localparam int SYNC_W = 6;
   localparam int SYN_TRIP = 0;
   localparam int SYN_BACKUP = 1;
   localparam int SYN_LOW = 2;
   localparam int SYN_KICK = 3;
   localparam int SYN_FLOAT = 4;
   localparam int SYN_CS = 5;
   // Trip and chip-select idle in their safe level
   localparam logic [SYNC_W-1:0] SYNC_RST = 6'h21;

   // ****************************************
   // States
   // ****************************************
   typedef enum logic {RST_RUN, RST_HOLD} ssr_rst_state_e;
   typedef enum logic [1:0] {CS_SHUT, CS_PASS, CS_GRACE} ssr_cs_state_e;

   function automatic logic ssr_gate_open(input ssr_cs_state_e s);
      ssr_gate_open = (s == CS_PASS) || (s == CS_GRACE);
   endfunction

endpackage

/* src/ssr_sync.sv */
// Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes each lane is a slow level; no bus coherence between lanes.
`timescale 1ns/10ps
`default_nettype none

module ssr_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
)(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta;

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         meta <= RESET_VAL;
         sync_out <= RESET_VAL;
      end
      else
      begin
         meta <= async_in;
         sync_out <= meta;
      end
   end

endmodule

`default_nettype wire

/* src/ssr_supervisor.sv */
// Supply supervisor: timed reset, power-fail warning, supply select,
// and either a watchdog with active-high reset or a chip-select gate.
// Assumes comparator flags and pins are asynchronous levels.
//
// Contract
// - Supply below trip level forces reset outputs asserted.
// - Reset holds at least 200ms after its cause ends.
// - Dropping below trip during the hold restarts the timeout from zero.
// - Watchdog expiry starts the same timed reset.
// - In the watchdog variant active-high reset is the inverse of active-low reset; the gate variant holds it low.
// - Warning output goes low when the low-line flag trips.
// - Backup supply chosen only when below trip and below backup level.
// - Backup level above main supply never causes reset by itself.
// - Backup mode forces warning low, resets asserted, gated select high.
// - No watchdog edge for 1.6s starts a timed reset.
// - Watchdog timer cleared on reset and on any input edge.
// - Watchdog frozen at zero during reset, counts right after release.
// - Floating watchdog input disables it; processor toggles or leaves open.
// - Normal operation passes chip-select straight through the gate.
// - Chip-select path disabled while reset is asserted, except during the grace period.
// - Trip during an active select keeps the gate open up to 18us.
// - Select still low at grace end closes gate, output high.
// - Select raised during grace closes gate at once.
// - Closed gate stays high even if select falls again.
// - On power-up select stays isolated until reset release.
`timescale 1ns/10ps
`default_nettype none

module ssr_supervisor #(
   parameter bit WATCHDOG_VARIANT = 1'b1,
   parameter logic [ssr_pkg::CNT_W-1:0] RST_CYCLES_P = ssr_pkg::RST_CYCLES,
   parameter logic [ssr_pkg::CNT_W-1:0] WDT_CYCLES_P = ssr_pkg::WDT_CYCLES
)(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Comparator flags
   input wire logic below_trip_in,
   input wire logic below_backup_in,
   input wire logic low_line_in,
   // Watchdog pin
   input wire logic watchdog_kick_in,
   input wire logic watchdog_float_in,
   // Chip-select pin
   input wire logic chip_select_n_in,
   // Reset, warning, supply select
   output logic reset_n_out,
   output logic reset_out,
   output logic power_fail_warning_n_out,
   output logic backup_select_out,
   // Pin status
   output logic watchdog_hiz_out,
   output logic chip_select_n_out,
   output logic chip_select_hiz_out
);

   import ssr_pkg::*;

   // ****************************************
   // Input synchronisers
   // ****************************************
   logic [SYNC_W-1:0] sync_q;
   logic trip_s;
   logic backup_s;
   logic low_s;
   logic kick_s;
   logic float_s;
   logic cs_n_s;

   ssr_sync #(
      .WIDTH(SYNC_W),
      .RESET_VAL(SYNC_RST)
   ) u_sync (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .async_in({chip_select_n_in, watchdog_float_in, watchdog_kick_in,
                 low_line_in, below_backup_in, below_trip_in}),
      .sync_out(sync_q)
   );

   assign trip_s = sync_q[SYN_TRIP];
   assign backup_s = sync_q[SYN_BACKUP];
   assign low_s = sync_q[SYN_LOW];
   assign kick_s = sync_q[SYN_KICK];
   assign float_s = sync_q[SYN_FLOAT];
   assign cs_n_s = sync_q[SYN_CS];

   // ****************************************
   // Reset hold timer
   // ****************************************
   ssr_rst_state_e rst_state;
   logic [CNT_W-1:0] hold_cnt;
   logic wdt_expire;
   logic in_backup;
   logic enter_now;
   logic release_now;
   logic next_hold;

   assign in_backup = trip_s & backup_s;
   assign enter_now = (rst_state == RST_RUN) && (trip_s || wdt_expire);
   assign release_now = (rst_state == RST_HOLD) && !trip_s &&
                        (hold_cnt == RST_CYCLES_P - CNT_ONE);
   assign next_hold = enter_now || ((rst_state == RST_HOLD) && !release_now);

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rst_state <= RST_HOLD;
         hold_cnt <= CNT_ZERO;
      end
      else
      begin
         case (rst_state)
            RST_RUN:
            begin
               if (enter_now)
               begin
                  rst_state <= RST_HOLD;
               end
               hold_cnt <= CNT_ZERO;
            end
            RST_HOLD:
            begin
               if (trip_s)
               begin
                  hold_cnt <= CNT_ZERO;
               end
               else if (release_now)
               begin
                  rst_state <= RST_RUN;
                  hold_cnt <= CNT_ZERO;
               end
               else
               begin
                  hold_cnt <= hold_cnt + CNT_ONE;
               end
            end
            default:
            begin
               rst_state <= RST_HOLD;
               hold_cnt <= CNT_ZERO;
            end
         endcase
      end
   end

   // ****************************************
   // Reset, warning and supply outputs
   // ****************************************
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         reset_n_out <= 1'b0;
         reset_out <= WATCHDOG_VARIANT;
         power_fail_warning_n_out <= 1'b0;
         backup_select_out <= 1'b0;
      end
      else
      begin
         reset_n_out <= ~next_hold;
         reset_out <= WATCHDOG_VARIANT & next_hold;
         power_fail_warning_n_out <= ~(low_s | in_backup);
         backup_select_out <= in_backup;
      end
   end

   // Cycles spent in reset since the cause went away
   logic [CNT_W-1:0] quiet_cnt;

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         quiet_cnt <= CNT_ZERO;
      end
      else if (reset_n_out || trip_s)
      begin
         quiet_cnt <= CNT_ZERO;
      end
      else
      begin
         quiet_cnt <= quiet_cnt + CNT_ONE;
      end
   end

   chk_trip_resets: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      trip_s |=> !reset_n_out)
      else $error("reset not asserted on trip");

   chk_hold_timeout: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      $rose(reset_n_out) |-> (quiet_cnt == RST_CYCLES_P))
      else $error("reset released with wrong hold time");

   chk_no_spurious: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (!trip_s && reset_n_out && !wdt_expire) |=> reset_n_out)
      else $error("reset without trip or expiry");

   chk_supply_select: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      in_backup |=> backup_select_out)
      else $error("supply select wrong");

   chk_main_select: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      !in_backup |=> !backup_select_out)
      else $error("backup kept without cause");

   chk_warning_low: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (low_s || in_backup) |=> !power_fail_warning_n_out)
      else $error("warning not low");

   chk_backup_outputs: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      backup_select_out |-> (!reset_n_out && !power_fail_warning_n_out))
      else $error("backup outputs wrong");

   cov_reset_release: cover property (
      @(posedge clk_in) disable iff (!rst_n_in)
      $rose(reset_n_out));

   cov_backup_entry: cover property (
      @(posedge clk_in) disable iff (!rst_n_in)
      $rose(backup_select_out));

   // ****************************************
   // Variant logic
   // ****************************************
   generate
      if (WATCHDOG_VARIANT)
      begin : g_wdt
         logic kick_prev;
         logic kick_edge;
         logic wdt_clear;
         logic [CNT_W-1:0] wdt_cnt;

         assign kick_edge = kick_s ^ kick_prev;
         assign wdt_clear = (rst_state == RST_HOLD) || kick_edge || float_s;
         assign wdt_expire = (rst_state == RST_RUN) && !wdt_clear &&
                             (wdt_cnt == WDT_CYCLES_P - CNT_ONE);

         always_ff @(posedge clk_in or negedge rst_n_in)
         begin
            if (!rst_n_in)
            begin
               kick_prev <= 1'b0;
               wdt_cnt <= CNT_ZERO;
               watchdog_hiz_out <= 1'b0;
            end
            else
            begin
               kick_prev <= kick_s;
               if (wdt_clear || wdt_expire)
               begin
                  wdt_cnt <= CNT_ZERO;
               end
               else
               begin
                  wdt_cnt <= wdt_cnt + CNT_ONE;
               end
               watchdog_hiz_out <= in_backup;
            end
         end

         always_ff @(posedge clk_in or negedge rst_n_in)
         begin
            if (!rst_n_in)
            begin
               chip_select_n_out <= 1'b1;
               chip_select_hiz_out <= 1'b1;
            end
            else
            begin
               chip_select_n_out <= 1'b1;
               chip_select_hiz_out <= 1'b1;
            end
         end

         chk_reset_inverse: assert property (
            @(posedge clk_in) disable iff (!rst_n_in)
            reset_out == !reset_n_out)
            else $error("reset outputs not inverse");

         chk_wdt_expiry: assert property (
            @(posedge clk_in) disable iff (!rst_n_in)
            wdt_expire |=> (!reset_n_out && reset_out && wdt_cnt == CNT_ZERO))
            else $error("expiry did not reset");

         chk_wdt_kick: assert property (
            @(posedge clk_in) disable iff (!rst_n_in)
            (kick_edge && reset_n_out) |=> (wdt_cnt == CNT_ZERO))
            else $error("kick did not clear timer");

         chk_wdt_frozen: assert property (
            @(posedge clk_in) disable iff (!rst_n_in)
            (rst_state == RST_HOLD) |=> (wdt_cnt == CNT_ZERO))
            else $error("timer counts in reset");

         chk_wdt_start: assert property (
            @(posedge clk_in) disable iff (!rst_n_in)
            ($rose(reset_n_out) && !kick_edge && !float_s) |=> (wdt_cnt == CNT_ONE))
            else $error("timer not counting after release");

         chk_wdt_disabled: assert property (
            @(posedge clk_in) disable iff (!rst_n_in)
            float_s |=> (wdt_cnt == CNT_ZERO))
            else $error("floating input did not disable");

         cov_wdt_expire: cover property (
            @(posedge clk_in) disable iff (!rst_n_in)
            wdt_expire);
      end
      else
      begin : g_cs
         ssr_cs_state_e cs_state;
         ssr_cs_state_e next_cs;
         logic [GRACE_W-1:0] grace_cnt;
         logic grace_end;

         assign wdt_expire = 1'b0;
         assign grace_end = (grace_cnt == GRACE_CYCLES - GRACE_ONE);

         always_comb
         begin
            next_cs = cs_state;
            case (cs_state)
               CS_SHUT:
               begin
                  if (!next_hold)
                  begin
                     next_cs = CS_PASS;
                  end
               end
               CS_PASS:
               begin
                  if (in_backup)
                  begin
                     next_cs = CS_SHUT;
                  end
                  else if (trip_s && !cs_n_s)
                  begin
                     next_cs = CS_GRACE;
                  end
                  else if (next_hold)
                  begin
                     next_cs = CS_SHUT;
                  end
               end
               CS_GRACE:
               begin
                  if (in_backup || cs_n_s || grace_end)
                  begin
                     next_cs = CS_SHUT;
                  end
               end
               default:
               begin
                  next_cs = CS_SHUT;
               end
            endcase
         end

         always_ff @(posedge clk_in or negedge rst_n_in)
         begin
            if (!rst_n_in)
            begin
               cs_state <= CS_SHUT;
               grace_cnt <= GRACE_ZERO;
            end
            else
            begin
               cs_state <= next_cs;
               if ((cs_state == CS_GRACE) && (next_cs == CS_GRACE))
               begin
                  grace_cnt <= grace_cnt + GRACE_ONE;
               end
               else
               begin
                  grace_cnt <= GRACE_ZERO;
               end
            end
         end

         always_ff @(posedge clk_in or negedge rst_n_in)
         begin
            if (!rst_n_in)
            begin
               chip_select_n_out <= 1'b1;
               chip_select_hiz_out <= 1'b1;
               watchdog_hiz_out <= 1'b1;
            end
            else
            begin
               chip_select_n_out <= ssr_gate_open(next_cs) ? cs_n_s : 1'b1;
               chip_select_hiz_out <= !ssr_gate_open(next_cs);
               watchdog_hiz_out <= 1'b1;
            end
         end

         chk_cs_pass: assert property (
            @(posedge clk_in) disable iff (!rst_n_in)
            (cs_state == CS_PASS && next_cs == CS_PASS) |=> (chip_select_n_out == $past(cs_n_s)))
            else $error("select not passed");

         chk_cs_shut: assert property (
            @(posedge clk_in) disable iff (!rst_n_in)
            (cs_state == CS_SHUT) |-> (chip_select_n_out && chip_select_hiz_out))
            else $error("closed gate not high");

         chk_cs_in_reset: assert property (
            @(posedge clk_in) disable iff (!rst_n_in)
            !reset_n_out |-> (cs_state != CS_PASS))
            else $error("gate passing during reset");

         chk_grace_entry: assert property (
            @(posedge clk_in) disable iff (!rst_n_in)
            (cs_state == CS_PASS && trip_s && !cs_n_s && !in_backup)
            |=> (cs_state == CS_GRACE && !chip_select_n_out))
            else $error("grace not entered");

         chk_grace_timeout: assert property (
            @(posedge clk_in) disable iff (!rst_n_in)
            (cs_state == CS_GRACE && grace_end) |=> (cs_state == CS_SHUT && chip_select_n_out))
            else $error("grace overran");

         chk_grace_release: assert property (
            @(posedge clk_in) disable iff (!rst_n_in)
            (cs_state == CS_GRACE && cs_n_s) |=> (cs_state == CS_SHUT && chip_select_n_out))
            else $error("gate not closed on select rise");

         chk_backup_gate: assert property (
            @(posedge clk_in) disable iff (!rst_n_in)
            backup_select_out |-> (chip_select_n_out && chip_select_hiz_out))
            else $error("gate open in backup");

         cov_grace_timeout: cover property (
            @(posedge clk_in) disable iff (!rst_n_in)
            cs_state == CS_GRACE && grace_end && !cs_n_s);
      end
   endgenerate

endmodule

`default_nettype wire

/* sim/ssr_cpu_model.sv */
// Processor-side model: watchdog kicks and RAM write strobes.
// Assumes the bench seeds $urandom and sets the controls just after the edge.
`timescale 1ns/10ps
`default_nettype none

module ssr_cpu_model (
   // Clock
   input wire logic clk_in,
   // Controls
   input wire logic kick_en_in,
   input wire logic float_en_in,
   input wire logic write_go_in,
   input wire logic [15:0] write_len_in,
   // Pins
   output logic kick_out,
   output logic float_out,
   output logic chip_select_n_out
);
   int gap = 4;
   int gap_cnt = 0;
   int wr_cnt = 0;
   logic ke;
   logic fe;
   logic wg;
   int wl;

   initial
   begin
      kick_out = 1'b0;
      float_out = 1'b0;
      chip_select_n_out = 1'b1;
   end

   // ****************
   // Kicks at random spacing, or a floating pin that wanders
   // ****************
   always @(posedge clk_in)
   begin
      ke = kick_en_in;
      fe = float_en_in;
      wg = write_go_in;
      wl = write_len_in;
      #1;
      float_out <= fe;
      gap_cnt <= gap_cnt + 1;
      if (fe)
         kick_out <= !kick_out;
      else if (ke && gap_cnt >= gap)
      begin
         kick_out <= !kick_out;
         gap_cnt <= 0;
         gap <= $urandom_range(40, 2);
      end
      if (wg)
      begin
         chip_select_n_out <= 1'b0;
         wr_cnt <= wl;
      end
      else if (wr_cnt > 1)
         wr_cnt <= wr_cnt - 1;
      else
         chip_select_n_out <= 1'b1;
   end
endmodule

`default_nettype wire

/* sim/ssr_supervisor_bench.sv */
// Bench for both supervisor variants, checked cycle by cycle against a model.
// Assumes shortened reset and watchdog counts; grace count is the package's.
`timescale 1ns/10ps
`default_nettype none

module ssr_supervisor_bench;
   import ssr_pkg::*;
   localparam int RST = 20;
   localparam int WDT = 50;
   localparam int GRACE = int'(GRACE_CYCLES);
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic trip = 1'b0;
   logic bkp = 1'b0;
   logic low = 1'b0;
   logic kick_en = 1'b1;
   logic float_en = 1'b0;
   logic write_go = 1'b0;
   logic [15:0] write_len = 16'h0001;
   logic kick;
   logic flt_pin;
   logic cs_n;
   logic [1:0] rn, ro, wn, bs, whz, csn, cshz;
   logic [1:0] m_rn, m_wn, m_bs, m_whz, m_csn, m_cshz;
   logic [SYNC_W-1:0] p1, p2;
   logic kprev, t, b, l, k, f, c, bu, ex, rel;
   int hold[2], rc[2], wc[2], gs[2], gc[2];
   int n_errors = 0;
   int num_checks = 0;

   always #2.5 clk_in = !clk_in;

   ssr_cpu_model u_ssr_cpu_model (.clk_in(clk_in), .kick_en_in(kick_en), .float_en_in(float_en),
      .write_go_in(write_go), .write_len_in(write_len), .kick_out(kick), .float_out(flt_pin),
      .chip_select_n_out(cs_n));
   ssr_supervisor #(.WATCHDOG_VARIANT(1'b1), .RST_CYCLES_P(29'(RST)), .WDT_CYCLES_P(29'(WDT)))
      u_ssr_supervisor (.clk_in(clk_in), .rst_n_in(rst_n_in), .below_trip_in(trip),
      .below_backup_in(bkp), .low_line_in(low), .watchdog_kick_in(kick), .watchdog_float_in(flt_pin),
      .chip_select_n_in(cs_n), .reset_n_out(rn[1]), .reset_out(ro[1]), .power_fail_warning_n_out(wn[1]),
      .backup_select_out(bs[1]), .watchdog_hiz_out(whz[1]), .chip_select_n_out(csn[1]),
      .chip_select_hiz_out(cshz[1]));
   ssr_supervisor #(.WATCHDOG_VARIANT(1'b0), .RST_CYCLES_P(29'(RST)), .WDT_CYCLES_P(29'(WDT)))
      u_ssr_supervisor_gate (.clk_in(clk_in), .rst_n_in(rst_n_in), .below_trip_in(trip),
      .below_backup_in(bkp), .low_line_in(low), .watchdog_kick_in(kick), .watchdog_float_in(flt_pin),
      .chip_select_n_in(cs_n), .reset_n_out(rn[0]), .reset_out(ro[0]), .power_fail_warning_n_out(wn[0]),
      .backup_select_out(bs[0]), .watchdog_hiz_out(whz[0]), .chip_select_n_out(csn[0]),
      .chip_select_hiz_out(cshz[0]));

   // ****************
   // Reference model; index 1 is the watchdog variant, 0 the gate variant
   // ****************
   always @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         p1 = SYNC_RST;
         p2 = SYNC_RST;
         kprev = 1'b0;
         for (int v = 0; v < 2; v++)
         begin
            hold[v] = 1; rc[v] = 0; wc[v] = 0; gs[v] = 0; gc[v] = 0;
            m_rn[v] = 1'b0; m_wn[v] = 1'b0; m_bs[v] = 1'b0; m_whz[v] = (v == 0); m_csn[v] = 1'b1;
            m_cshz[v] = 1'b1;
         end
      end
      else
      begin
         t = p2[SYN_TRIP]; b = p2[SYN_BACKUP]; l = p2[SYN_LOW];
         k = p2[SYN_KICK]; f = p2[SYN_FLOAT]; c = p2[SYN_CS];
         bu = t & b;
         for (int v = 0; v < 2; v++)
         begin
            ex = 1'b0;
            rel = 1'b0;
            if (v == 1)
            begin
               if (hold[v] != 0 || k != kprev || f)
                  wc[v] = 0;
               else if (wc[v] == WDT - 1)
               begin
                  ex = 1'b1;
                  wc[v] = 0;
               end
               else
                  wc[v]++;
            end
            if (t || ex)
            begin
               hold[v] = 1;
               rc[v] = 0;
            end
            else if (hold[v] != 0)
            begin
               if (rc[v] == RST - 1)
               begin
                  hold[v] = 0;
                  rel = 1'b1;
               end
               else
                  rc[v]++;
            end
            if (gs[v] == 0)
               gs[v] = rel ? 1 : 0;
            else if (gs[v] == 1)
            begin
               if (t)
                  gs[v] = (!c && !bu) ? 2 : 0;
               gc[v] = 0;
            end
            else if (c || bu || gc[v] == GRACE - 1)
               gs[v] = 0;
            else
               gc[v]++;
            m_rn[v] = (hold[v] == 0);
            m_wn[v] = !(l | bu);
            m_bs[v] = bu;
            m_whz[v] = (v == 1) ? bu : 1'b1;
            m_csn[v] = (v == 1 || gs[v] == 0) ? 1'b1 : c;
            m_cshz[v] = (v == 1) || (gs[v] == 0);
         end
         kprev = k;
         p2 = p1;
         p1 = {c_in_pins()};
      end
   end

   function automatic logic [SYNC_W-1:0] c_in_pins();
      logic [SYNC_W-1:0] r;
      r = '0;
      r[SYN_TRIP] = trip; r[SYN_BACKUP] = bkp; r[SYN_LOW] = low;
      r[SYN_KICK] = kick; r[SYN_FLOAT] = flt_pin; r[SYN_CS] = cs_n;
      return r;
   endfunction

   // ****************
   // Checking and closing
   // ****************
   task automatic check_bit(input string name, input logic exp, input logic got);
      num_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] %s expected %b seen %b at %0t", name, exp, got, $time);
      end
   endtask

   always @(negedge clk_in)
   begin
      for (int v = 0; v < 2; v++)
      begin
         check_bit("reset_n_out", m_rn[v], rn[v]);
         check_bit("reset_out", (v == 1) ? !m_rn[v] : 1'b0, ro[v]);
         check_bit("power_fail_warning_n_out", m_wn[v], wn[v]);
         check_bit("backup_select_out", m_bs[v], bs[v]);
         check_bit("watchdog_hiz_out", m_whz[v], whz[v]);
         check_bit("chip_select_n_out", m_csn[v], csn[v]);
         check_bit("chip_select_hiz_out", m_cshz[v], cshz[v]);
      end
   end

   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clk_in);
      n_errors++;
      summarize();
   end

   // ****************
   // Stimulus
   // ****************
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask

   task automatic flags(input logic tv, input logic bv, input logic lv);
      cyc(1);
      trip = tv;
      bkp = bv;
      low = lv;
   endtask

   task automatic write(input int len);
      cyc(1);
      write_go = 1'b1;
      write_len = 16'(len);
      cyc(1);
      write_go = 1'b0;
   endtask

   initial
   begin
      void'($urandom(78864));
      cyc(4);
      rst_n_in = 1'b1;
      write(30);
      cyc(40);
      for (int i = 0; i < 6; i++)
      begin
         write($urandom_range(12, 3));
         cyc(40);
      end
      kick_en = 1'b0;
      cyc(150);
      float_en = 1'b1;
      cyc(200);
      float_en = 1'b0;
      kick_en = 1'b1;
      flags(1'b0, 1'b0, 1'b1);
      cyc(10);
      flags(1'b0, 1'b1, 1'b0);
      cyc(40);
      flags(1'b1, 1'b0, 1'b0);
      cyc(5);
      flags(1'b0, 1'b0, 1'b0);
      cyc(10);
      flags(1'b1, 1'b0, 1'b0);
      cyc(5);
      flags(1'b0, 1'b0, 1'b0);
      cyc(40);
      write(100);
      cyc(5);
      flags(1'b1, 1'b0, 1'b0);
      cyc(120);
      write(10);
      cyc(30);
      flags(1'b0, 1'b0, 1'b0);
      cyc(40);
      write(4000);
      cyc(5);
      flags(1'b1, 1'b0, 1'b0);
      cyc(4100);
      flags(1'b0, 1'b0, 1'b0);
      cyc(40);
      write(30);
      cyc(4);
      flags(1'b1, 1'b1, 1'b0);
      cyc(50);
      flags(1'b0, 1'b0, 1'b0);
      cyc(40);
      summarize();
   end
endmodule

`default_nettype wire
